// *** rtl/cmh_handler.sv ***
// Purpose: message handler: RAM, interface sets, tx pick, filtering, flags
// Assumes: the bit stream processor hands over whole received frames
// Notes:   one transfer, scan step or pick per cycle, and a completion merges into it
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cmh_handler
  import cmh_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_ready,
  output logic             tx_load,
  output var cmh_frame_t   tx_frame,
  input  wire logic        tx_ok,
  input  wire logic        tx_fail,
  input  wire logic        rx_valid,
  input  wire cmh_frame_t  rx_frame,
  output logic             rx_accept
);

  cmh_state_t  state;
  cmh_state_t  next_state;
  logic [4:0]  scan_idx;
  logic [4:0]  next_scan_idx;
  cmh_ifset_t  ifr           [NUM_IF];
  cmh_ifset_t  next_ifr      [NUM_IF];
  cmh_obj_t    ram           [NUM_OBJ];
  cmh_obj_t    next_ram      [NUM_OBJ];
  cmh_frame_t  rx_hold;
  cmh_frame_t  next_rx_hold;
  logic        rx_pend;
  logic        next_rx_pend;
  logic        tx_busy;
  logic        next_tx_busy;
  logic [4:0]  tx_idx;
  logic [4:0]  next_tx_idx;
  logic        next_tx_load;
  cmh_frame_t  next_tx_frame;
  logic [5:0]  irq_src;
  logic [5:0]  next_irq_src;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        tx_found;
  logic [4:0]  tx_pick;
  logic [31:0] txrq_vec;
  logic [31:0] fresh_vec;
  logic [31:0] valid_vec;
  logic        apb_setup;
  logic        apb_write;
  logic [3:0]  page;
  logic [7:0]  ofs;

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;
  assign page      = paddr[11:8];
  assign ofs       = paddr[7:0];
  assign pready    = 1'b1;
  assign rx_accept = ~rx_pend;

  function automatic logic accepts(input cmh_obj_t o, input cmh_frame_t f);
    logic [28:0] m;
    logic        hit;
    m = o.use_filter ? o.identifier_mask_bits : '1;
    if (f.extended) begin
      hit = ((o.identifier ^ f.ident) & m) == 29'h0;
    end else begin
      hit = ((o.identifier[28:18] ^ f.ident[28:18]) & m[28:18]) == 11'h0;
    end
    if (!o.use_filter || o.extended_flag_compare)
      hit = hit & (o.extended_identifier_flag == f.extended);
    if (!o.use_filter || o.tx_flag_compare)
      hit = hit & (o.object_is_transmit == f.remote);
    return o.object_valid & hit;
  endfunction

  function automatic logic [15:0] ctrl_word(input cmh_obj_t o);
    return {o.fresh_content, o.overrun_flag, o.irq_pending, o.use_filter,
            o.tx_done_irq_enable, o.rx_done_irq_enable, o.remote_autoreply,
            o.send_request, o.end_of_buffer, 3'b000, o.length_code};
  endfunction

  // returns {hit, word} for an interface set register
  function automatic logic [16:0] if_read(input cmh_ifset_t r,
                                          input logic [7:0] a);
    logic [16:0] v;
    v = {1'b1, 16'h0000};
    case (a)
      OFS_CMD_REQ:  v[15:0] = {r.busy, 9'h000, r.object_number};
      OFS_CMD_MASK: v[15:0] = {8'h00, r.cmd_mask};
      OFS_MASK_LO:  v[15:0] = r.mask_lo;
      OFS_MASK_HI:  v[15:0] = r.mask_hi;
      OFS_IDENT_LO: v[15:0] = r.ident_lo;
      OFS_IDENT_HI: v[15:0] = r.ident_hi;
      OFS_MSG_CTRL: v[15:0] = r.msg_ctrl;
      OFS_DATA_A1:  v[15:0] = r.data[15:0];
      OFS_DATA_A2:  v[15:0] = r.data[31:16];
      OFS_DATA_B1:  v[15:0] = r.data[47:32];
      OFS_DATA_B2:  v[15:0] = r.data[63:48];
      default:      v[16]   = 1'b0;
    endcase
    return v;
  endfunction

  // pick: loop runs downward so the lowest eligible number is kept last
  always_comb begin
    tx_found  = 1'b0;
    tx_pick   = 5'h00;
    txrq_vec  = 32'h0;
    fresh_vec = 32'h0;
    valid_vec = 32'h0;
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      txrq_vec[i]  = ram[i].send_request;
      fresh_vec[i] = ram[i].fresh_content;
      valid_vec[i] = ram[i].object_valid;
      if (ram[i].object_valid && ram[i].object_is_transmit &&
          ram[i].send_request) begin
        tx_found = 1'b1;
        tx_pick  = 5'(i);
      end
    end
  end

  // read data is captured in the setup phase, so no wait state is needed
  always_comb begin
    logic [16:0] rv;
    rv           = 17'h00000;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (apb_setup) begin
      next_prdata  = 32'h0;
      next_pslverr = 1'b1;
      if (page == PAGE_GLOBAL) begin
        next_pslverr = 1'b0;
        case (ofs)
          OFS_IRQ_SRC:   next_prdata = {26'h0, irq_src};
          OFS_TXRQ_VEC:  next_prdata = txrq_vec;
          OFS_FRESH_VEC: next_prdata = fresh_vec;
          OFS_VALID_VEC: next_prdata = valid_vec;
          default:       next_pslverr = 1'b1;
        endcase
      end
      for (int s = 0; s < NUM_IF; s++) begin
        if (page == PAGE_IF0 + 4'(s)) begin
          rv           = if_read(ifr[s], ofs);
          next_prdata  = {16'h0000, rv[15:0]};
          next_pslverr = ~rv[16];
        end
      end
    end
  end

  always_comb begin
    cmh_obj_t   o;
    logic [7:0] cm;
    logic [4:0] idx;
    logic       sel;
    o             = '0;
    cm            = 8'h00;
    idx           = 5'h00;
    sel           = 1'b0;
    next_state    = state;
    next_scan_idx = scan_idx;
    next_ifr      = ifr;
    next_ram      = ram;
    next_rx_hold  = rx_hold;
    next_rx_pend  = rx_pend;
    next_tx_busy  = tx_busy;
    next_tx_idx   = tx_idx;
    next_tx_load  = 1'b0;
    next_tx_frame = tx_frame;
    next_irq_src  = irq_src;

    // software writes; a set is frozen while its transfer is pending
    if (apb_write) begin
      for (int s = 0; s < NUM_IF; s++) begin
        if (page == PAGE_IF0 + 4'(s) && !ifr[s].busy) begin
          case (ofs)
            OFS_CMD_REQ: begin
              next_ifr[s].object_number = pwdata[5:0];
              next_ifr[s].busy          = 1'b1;
            end
            OFS_CMD_MASK: next_ifr[s].cmd_mask       = pwdata[7:0];
            OFS_MASK_LO:  next_ifr[s].mask_lo        = pwdata[15:0];
            OFS_MASK_HI:  next_ifr[s].mask_hi        = pwdata[15:0];
            OFS_IDENT_LO: next_ifr[s].ident_lo       = pwdata[15:0];
            OFS_IDENT_HI: next_ifr[s].ident_hi       = pwdata[15:0];
            OFS_MSG_CTRL: next_ifr[s].msg_ctrl       = pwdata[15:0];
            OFS_DATA_A1:  next_ifr[s].data[15:0]     = pwdata[15:0];
            OFS_DATA_A2:  next_ifr[s].data[31:16]    = pwdata[15:0];
            OFS_DATA_B1:  next_ifr[s].data[47:32]    = pwdata[15:0];
            OFS_DATA_B2:  next_ifr[s].data[63:48]    = pwdata[15:0];
            default: ;
          endcase
        end
      end
    end

    unique case (state)
      ST_IDLE: begin
        if (ifr[0].busy || ifr[1].busy) begin
          sel = ~ifr[0].busy;
          cm  = ifr[sel].cmd_mask;
          idx = 5'(ifr[sel].object_number - 6'd1);
          next_ifr[sel].busy = 1'b0;
          if (ifr[sel].object_number != 6'd0 &&
              ifr[sel].object_number <= 6'd32) begin
            o = ram[idx];
            if (cm[CM_WRITE]) begin
              if (cm[CM_MASK]) begin
                o.identifier_mask_bits  = {ifr[sel].mask_hi[12:0],
                                           ifr[sel].mask_lo};
                o.extended_flag_compare = ifr[sel].mask_hi[BIT_EXTENDED_FLAG_COMPARE];
                o.tx_flag_compare       = ifr[sel].mask_hi[BIT_TX_FLAG_COMPARE];
              end
              if (cm[CM_IDENT]) begin
                o.identifier = {ifr[sel].ident_hi[12:0], ifr[sel].ident_lo};
                o.extended_identifier_flag = ifr[sel].ident_hi[BIT_XTD];
                o.object_is_transmit       = ifr[sel].ident_hi[BIT_DIR];
                o.object_valid             = ifr[sel].ident_hi[BIT_VALID];
              end
              if (cm[CM_CTRL]) begin
                o.fresh_content      = ifr[sel].msg_ctrl[BIT_FRESH];
                o.overrun_flag       = ifr[sel].msg_ctrl[BIT_OVR];
                o.irq_pending        = ifr[sel].msg_ctrl[BIT_IRQP];
                o.use_filter         = ifr[sel].msg_ctrl[BIT_UFILT];
                o.tx_done_irq_enable = ifr[sel].msg_ctrl[BIT_TX_DONE_IRQ_ENABLE];
                o.rx_done_irq_enable = ifr[sel].msg_ctrl[BIT_RX_DONE_IRQ_ENABLE];
                o.remote_autoreply   = ifr[sel].msg_ctrl[BIT_RAUTO];
                o.send_request       = ifr[sel].msg_ctrl[BIT_TXRQ];
                o.end_of_buffer      = ifr[sel].msg_ctrl[BIT_EOBUF];
                o.length_code        = ifr[sel].msg_ctrl[3:0];
              end else if (cm[CM_FRESH_TXRQ]) begin
                o.send_request = 1'b1;
              end
              // no need to drop valid or send_request first
              if (cm[CM_DATA_LO]) o.data[31:0] = ifr[sel].data[31:0];
              if (cm[CM_DATA_HI]) o.data[63:32] = ifr[sel].data[63:32];
            end else begin
              if (cm[CM_MASK]) begin
                next_ifr[sel].mask_lo = o.identifier_mask_bits[15:0];
                next_ifr[sel].mask_hi = {o.extended_flag_compare,
                                         o.tx_flag_compare, 1'b0,
                                         o.identifier_mask_bits[28:16]};
              end
              if (cm[CM_IDENT]) begin
                next_ifr[sel].ident_lo = o.identifier[15:0];
                next_ifr[sel].ident_hi = {o.object_valid,
                                          o.extended_identifier_flag,
                                          o.object_is_transmit,
                                          o.identifier[28:16]};
              end
              if (cm[CM_CTRL]) next_ifr[sel].msg_ctrl = ctrl_word(o);
              if (cm[CM_DATA_LO]) next_ifr[sel].data[31:0] = o.data[31:0];
              if (cm[CM_DATA_HI]) next_ifr[sel].data[63:32] = o.data[63:32];
              if (cm[CM_CLR_IRQ]) begin
                o.irq_pending = 1'b0;
                if (irq_src == ifr[sel].object_number) begin
                  next_irq_src = 6'd0;
                end
              end
              if (cm[CM_FRESH_TXRQ]) o.fresh_content = 1'b0;
            end
            next_ram[idx] = o;
          end
        end else if (rx_pend) begin
          next_state    = ST_SCAN;
          next_scan_idx = 5'h00;
        end else if (tx_ready && !tx_busy && tx_found) begin
          next_tx_load  = 1'b1;
          next_tx_busy  = 1'b1;
          next_tx_idx   = tx_pick;
          next_tx_frame = '{ram[tx_pick].identifier,
                            ram[tx_pick].extended_identifier_flag, 1'b0,
                            ram[tx_pick].length_code, ram[tx_pick].data};
          next_ram[tx_pick].fresh_content = 1'b0;
        end
      end
      ST_SCAN: begin
        if (accepts(ram[scan_idx], rx_hold)) begin
          o = ram[scan_idx];
          if (!rx_hold.remote) begin
            o.identifier  = rx_hold.ident;
            o.extended_identifier_flag = rx_hold.extended;
            o.length_code = rx_hold.length_code;
            o.data        = rx_hold.data;
            o.overrun_flag = o.overrun_flag | o.fresh_content;
            o.fresh_content = 1'b1;
            if (o.rx_done_irq_enable) begin
              o.irq_pending = 1'b1;
              next_irq_src  = {1'b0, scan_idx} + 6'd1;
            end
          end else if (o.remote_autoreply) begin
            o.send_request = 1'b1;
          end
          next_ram[scan_idx] = o;
          next_state   = ST_IDLE;
          next_rx_pend = 1'b0;
        end else if (scan_idx == 5'd31) begin
          next_state   = ST_IDLE;
          next_rx_pend = 1'b0;
        end else begin
          next_scan_idx = scan_idx + 5'd1;
        end
      end
    endcase

    // completion applies after any same-cycle transfer, so a fresh
    // refresh written now still keeps the request alive
    if (tx_busy && tx_ok) begin
      next_tx_busy = 1'b0;
      if (next_ram[tx_idx].tx_done_irq_enable) begin
        next_ram[tx_idx].irq_pending = 1'b1;
        next_irq_src = {1'b0, tx_idx} + 6'd1;
      end
      if (!next_ram[tx_idx].fresh_content) begin
        next_ram[tx_idx].send_request = 1'b0;
      end
    end else if (tx_busy && tx_fail) begin
      // request stays set; the next pick re-ranks all pending objects
      next_tx_busy = 1'b0;
    end

    // one frame held at a time; rx_accept low tells the source to wait
    if (rx_valid && !next_rx_pend) begin
      next_rx_hold = rx_frame;
      next_rx_pend = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      scan_idx <= 5'h00;
      ifr      <= '{default: IFSET_RESET};
      ram      <= '{default: '0};
      rx_hold  <= '0;
      rx_pend  <= 1'b0;
      tx_busy  <= 1'b0;
      tx_idx   <= 5'h00;
      tx_load  <= 1'b0;
      tx_frame <= '0;
      irq_src  <= 6'h00;
      prdata   <= 32'h0;
      pslverr  <= 1'b0;
    end else begin
      state    <= next_state;
      scan_idx <= next_scan_idx;
      ifr      <= next_ifr;
      ram      <= next_ram;
      rx_hold  <= next_rx_hold;
      rx_pend  <= next_rx_pend;
      tx_busy  <= next_tx_busy;
      tx_idx   <= next_tx_idx;
      tx_load  <= next_tx_load;
      tx_frame <= next_tx_frame;
      irq_src  <= next_irq_src;
      prdata   <= next_prdata;
      pslverr  <= next_pslverr;
    end
  end

endmodule
`default_nettype wire

// *** rtl/cmh_pkg.sv ***
// Purpose: constants, register layout and carriers of the message handler
// Assumes: 32 message objects, two interface register sets, APB access
// Notes:   a standard identifier travels in ident[28:18] of a frame
package cmh_pkg;

  localparam int NUM_OBJ = 32;
  localparam int NUM_IF  = 2;

  // address pages (paddr[11:8]) and word offsets (paddr[7:0])
  localparam logic [3:0] PAGE_GLOBAL   = 4'h0;
  localparam logic [3:0] PAGE_IF0      = 4'h1;
  localparam logic [7:0] OFS_IRQ_SRC   = 8'h00;
  localparam logic [7:0] OFS_TXRQ_VEC  = 8'h04;
  localparam logic [7:0] OFS_FRESH_VEC = 8'h08;
  localparam logic [7:0] OFS_VALID_VEC = 8'h0c;
  localparam logic [7:0] OFS_CMD_REQ   = 8'h00;
  localparam logic [7:0] OFS_CMD_MASK  = 8'h04;
  localparam logic [7:0] OFS_MASK_LO   = 8'h08;
  localparam logic [7:0] OFS_MASK_HI   = 8'h0c;
  localparam logic [7:0] OFS_IDENT_LO  = 8'h10;
  localparam logic [7:0] OFS_IDENT_HI  = 8'h14;
  localparam logic [7:0] OFS_MSG_CTRL  = 8'h18;
  localparam logic [7:0] OFS_DATA_A1   = 8'h1c;
  localparam logic [7:0] OFS_DATA_A2   = 8'h20;
  localparam logic [7:0] OFS_DATA_B1   = 8'h24;
  localparam logic [7:0] OFS_DATA_B2   = 8'h28;

  // command mask bits
  localparam int CM_WRITE      = 7;
  localparam int CM_MASK       = 6;
  localparam int CM_IDENT      = 5;
  localparam int CM_CTRL       = 4;
  localparam int CM_CLR_IRQ    = 3;
  localparam int CM_FRESH_TXRQ = 2;
  localparam int CM_DATA_LO    = 1;
  localparam int CM_DATA_HI    = 0;
  // command request, mask high, identifier high and control word bits
  localparam int BIT_REQ_BUSY  = 15;
  localparam int BIT_EXTENDED_FLAG_COMPARE      = 15;
  localparam int BIT_TX_FLAG_COMPARE      = 14;
  localparam int BIT_VALID     = 15;
  localparam int BIT_XTD       = 14;
  localparam int BIT_DIR       = 13;
  localparam int BIT_FRESH     = 15;
  localparam int BIT_OVR       = 14;
  localparam int BIT_IRQP      = 13;
  localparam int BIT_UFILT     = 12;
  localparam int BIT_TX_DONE_IRQ_ENABLE      = 11;
  localparam int BIT_RX_DONE_IRQ_ENABLE      = 10;
  localparam int BIT_RAUTO     = 9;
  localparam int BIT_TXRQ      = 8;
  localparam int BIT_EOBUF     = 7;

  localparam logic [15:0] RST_MASK_WORD = 16'hffff;
  localparam logic [15:0] RST_WORD      = 16'h0000;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SCAN = 2'b10} cmh_state_t;

  typedef struct packed {
    logic [28:0] ident;
    logic        extended;
    logic        remote;
    logic [3:0]  length_code;
    logic [63:0] data;
  } cmh_frame_t;

  typedef struct packed {
    logic [28:0] identifier_mask_bits;
    logic        extended_flag_compare;
    logic        tx_flag_compare;
    logic [28:0] identifier;
    logic        extended_identifier_flag;
    logic        object_is_transmit;
    logic        object_valid;
    logic        use_filter;
    logic        tx_done_irq_enable;
    logic        rx_done_irq_enable;
    logic        remote_autoreply;
    logic        end_of_buffer;
    logic [3:0]  length_code;
    logic        fresh_content;
    logic        overrun_flag;
    logic        irq_pending;
    logic        send_request;
    logic [63:0] data;
  } cmh_obj_t;

  typedef struct packed {
    logic [7:0]  cmd_mask;
    logic [5:0]  object_number;
    logic        busy;
    logic [15:0] mask_lo;
    logic [15:0] mask_hi;
    logic [15:0] ident_lo;
    logic [15:0] ident_hi;
    logic [15:0] msg_ctrl;
    logic [63:0] data;
  } cmh_ifset_t;

  localparam cmh_ifset_t IFSET_RESET = '{
    cmd_mask: 8'h00, object_number: 6'h00, busy: 1'b0,
    mask_lo: RST_MASK_WORD, mask_hi: RST_MASK_WORD,
    ident_lo: RST_WORD, ident_hi: RST_WORD, msg_ctrl: RST_WORD,
    data: 64'h0};

endpackage

// *** tb/cmh_bsp_model.sv ***
// Purpose: far-side model of the bit stream processor, transmit side
// Assumes: one frame in flight at a time
// Notes:   LAT sets the frame length in cycles; fail_next spoils a frame
`timescale 1ns/1ps
`default_nettype none
module cmh_bsp_model #(
  parameter int LAT = 6
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic stall,
  input  wire logic fail_next,
  input  wire logic tx_load,
  output logic      tx_ready,
  output logic      tx_ok,
  output logic      tx_fail
);
  int   cnt;
  logic fail;
  // stall models a slow shift register, so requests can pile up
  assign tx_ready = (cnt == 0) && !stall;
  always @(posedge pclk or negedge presetn) begin
    tx_ok <= 1'b0;
    tx_fail <= 1'b0;
    if (!presetn) begin
      cnt <= 0;
      fail <= 1'b0;
    end else if (tx_load) begin
      cnt <= LAT;
      fail <= fail_next;
    end else if (cnt == 1) begin
      cnt <= 0;
      tx_ok <= !fail;
      tx_fail <= fail;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// *** tb/cmh_handler_props.sv ***
// Purpose: port assertions of the message handler
// Assumes: one clock, presetn asynchronous and active low
// Notes:   in_flight mirrors who owns the shift register
`timescale 1ns/1ps
`default_nettype none
module cmh_handler_props
  import cmh_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        tx_ready,
  input wire logic        tx_load,
  input wire cmh_frame_t  tx_frame,
  input wire logic        tx_ok,
  input wire logic        tx_fail,
  input wire logic        rx_valid,
  input wire logic        rx_accept
);
  logic in_flight;
  logic next_in_flight;
  always_comb begin
    next_in_flight = in_flight;
    if (tx_ok || tx_fail) next_in_flight = 1'b0;
    if (tx_load) next_in_flight = 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) in_flight <= 1'b0;
    else in_flight <= next_in_flight;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_one_frame; tx_load |-> !in_flight; endproperty
  property p_ready_first; tx_load |-> $past(tx_ready); endproperty
  property p_data_only; tx_load |-> !tx_frame.remote; endproperty
  property p_frame_hold; !tx_load |-> $stable(tx_frame); endproperty
  property p_rx_busy; rx_valid && rx_accept |=> !rx_accept; endproperty
  property p_rx_back; $fell(rx_accept) |-> ##[1:60] rx_accept; endproperty
  property p_retry; tx_fail |-> ##[1:80] tx_load; endproperty
  property p_rd_hold; $changed(prdata) |-> $past(psel && !penable);
  endproperty
  a_one_frame: assert property (p_one_frame)
    else $error("load while a frame is in flight");
  a_ready_first: assert property (p_ready_first)
    else $error("load without a ready shift register");
  a_data_only: assert property (p_data_only)
    else $error("loaded frame marked remote");
  a_frame_hold: assert property (p_frame_hold)
    else $error("frame changed without a load");
  a_rx_busy: assert property (p_rx_busy)
    else $error("second frame taken during scan");
  a_rx_back: assert property (p_rx_back)
    else $error("scan did not end in time");
  a_retry: assert property (p_retry)
    else $error("no retry after a failed frame");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved outside a setup phase");
  c_fail: cover property (tx_fail);
  c_ok: cover property (tx_ok);
  c_rx: cover property (rx_valid && rx_accept);
endmodule
bind cmh_handler cmh_handler_props i_cmh_handler_props (.pclk, .presetn,
  .psel, .penable, .prdata, .tx_ready, .tx_load, .tx_frame, .tx_ok,
  .tx_fail, .rx_valid, .rx_accept);
`default_nettype wire

// *** tb/tb_cmh_handler.sv ***
// Purpose: self-checking bench of the message handler
// Assumes: APB master without wait states on the slave side
// Notes:   transmitted frames are checked against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb_cmh_handler;
  import cmh_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        tx_ready, tx_load, tx_ok, tx_fail, stall, fail_next;
  logic        rx_valid, rx_accept;
  cmh_frame_t  tx_frame, rx_frame;
  cmh_frame_t  exp_q[$];
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;
  cmh_handler i_cmh_handler (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_ready, .tx_load,
    .tx_frame, .tx_ok, .tx_fail, .rx_valid, .rx_frame, .rx_accept);
  cmh_bsp_model i_cmh_bsp_model (.pclk, .presetn, .stall, .fail_next,
    .tx_load, .tx_ready, .tx_ok, .tx_fail);
  always #20 pclk = ~pclk;
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [127:0] seen,
                       input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask
  // a data word is always written whole, all four 16-bit halfwords
  task automatic put_data(input logic [63:0] d);
    for (int k = 0; k < 4; k++) begin
      wr(12'h11c + 12'(4 * k), {16'h0, d[16*k+:16]});
    end
  endtask
  task automatic go(input logic [11:0] b, input logic [5:0] n);
    logic [31:0] r;
    wr(b, {26'h0, n});
    do rd(b, r); while (r[15] !== 1'b0);
  endtask
  task automatic obj(input logic [5:0] n, input logic [15:0] ihi,
      input logic [15:0] ctl, input logic [63:0] d, input logic [15:0] m);
    wr(12'h104, 32'hf3);
    wr(12'h108, 32'hffff);
    wr(12'h10c, {16'h0, m});
    wr(12'h110, 32'h0);
    wr(12'h114, {16'h0, ihi});
    wr(12'h118, {16'h0, ctl});
    put_data(d);
    go(12'h100, n);
  endtask
  task automatic tx_obj(input logic [5:0] n, input logic [15:0] ctl,
                        output cmh_frame_t e);
    e = '0;
    e.ident[28:18] = 11'($urandom);
    e.length_code = 4'h8;
    e.data = {$urandom, $urandom};
    obj(n, {3'b101, e.ident[28:18], 2'b0}, ctl, e.data, 16'hffff);
  endtask
  task automatic send_rx(input logic [10:0] id, input logic [63:0] d);
    rx_frame <= '{ident: {id, 18'h0}, extended: 1'b0, remote: 1'b0,
                  length_code: 4'h8, data: d};
    rx_valid <= 1'b1;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_frame <= ~rx_frame;
    do @(posedge pclk); while (rx_accept !== 1'b1);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // second process: each load takes the oldest note off the queue
  always @(posedge pclk) begin
    if (tx_load === 1'b1) begin
      if (exp_q.size() == 0) check("spare load", 1, 0);
      else check("tx frame", tx_frame, exp_q.pop_front());
    end
  end
  initial begin
    cmh_frame_t f2, f5;
    logic [31:0] r;
    logic [63:0] d;
    void'($urandom(32'h0cca));
    {presetn, psel, penable, pwrite, rx_valid} <= '0;
    {paddr, pwdata, rx_frame} <= '0;
    stall <= 1'b1;
    fail_next <= 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    tx_obj(6'd5, 16'h8908, f5);
    tx_obj(6'd2, 16'h0108, f2);
    d = {$urandom, $urandom};
    wr(12'h104, 32'h83);
    put_data(d);
    go(12'h100, 6'd5);
    f5.data = d;
    exp_q.push_back(f2);
    exp_q.push_back(f2);
    exp_q.push_back(f5);
    stall <= 1'b0;
    @(posedge pclk iff tx_load);
    fail_next <= 1'b0;
    repeat (2) @(posedge pclk iff tx_ok);
    @(posedge pclk);
    rd(12'h004, r);
    check("send vector", r, 0);
    rd(12'h008, r);
    check("fresh vector", r, 0);
    rd(12'h000, r);
    check("irq source", r[5:0], 5);
    obj(6'd3, 16'h8154, 16'h1408, 64'h0, 16'h0);
    obj(6'd4, 16'h8154, 16'h0408, 64'h0, 16'hffff);
    send_rx(11'h055, {$urandom, $urandom});
    rd(12'h008, r);
    check("first match", r, 32'h4);
    d = {$urandom, $urandom};
    send_rx(11'h2aa, d);
    wr(12'h204, 32'h33);
    go(12'h200, 6'd3);
    rd(12'h218, r);
    check("rx control", r[15:0], 16'hf408);
    rd(12'h214, r);
    check("rx ident", r[15:0], 16'h8aa8);
    for (int k = 0; k < 4; k++) begin
      rd(12'h21c + 12'(4 * k), r);
      check("rx data", r[15:0], d[16*k+:16]);
    end
    rd(12'h000, r);
    check("rx irq source", r[5:0], 3);
    wr(12'h204, 32'h0c);
    go(12'h200, 6'd3);
    rd(12'h000, r);
    check("irq source cleared", r[5:0], 0);
    rd(12'h008, r);
    check("fresh cleared", r, 0);
    rd(12'h300, r);
    check("unmapped", err, 1);
    check("queue left", exp_q.size(), 0);
    complete_run();
  end
endmodule
`default_nettype wire
